// *** hw/cmas_pkg.sv ***
package cmas_pkg;
  localparam int ADDR_W  = 15;
  localparam int WORD_W  = 16;
  localparam int LINES_W = 8;
  localparam int Y_HI    = 11;
  localparam int Y_LO    = 6;
  localparam int X_HI    = 5;
  localparam int X_LO    = 0;
  localparam int MOD_BIT = 12;
  localparam int STK_HI  = 14;
  localparam int STK_LO  = 13;
  localparam int PAGE_HI = 9;
  localparam int PAGE_LO = 0;
  localparam int DIGIT_W = 3;
  localparam int IND_BIT = 15;
  localparam logic [ADDR_W-1:0] PC_INC  = 15'h0001;
  localparam logic [ADDR_W-1:0] PC_SKIP = 15'h0002;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [1:0] STACK_FIRST  = 2'h0;
  localparam logic [1:0] STACK_SECOND = 2'h1;

  typedef enum logic [1:0] {CMAS_FETCH, CMAS_INDIRECT, CMAS_EXECUTE} cmas_phase_t;

  typedef struct packed {
    logic [LINES_W-1:0] driver;
    logic [LINES_W-1:0] switch_sel;
  } cmas_line_sel_t;

  typedef struct packed {
    logic x_lower_module_enable;
    logic x_upper_module_enable;
    logic x_lower_module_enable_stack2;
    logic x_upper_module_enable_stack2;
    logic y_stack_first_enable;
    logic y_stack_second_enable;
  } cmas_enables_t;

  typedef struct packed {
    logic y_sw_to_drv;
    logic x_sw_to_drv;
  } cmas_dir_t;
endpackage

// *** hw/cmas_line_decoder.sv ***
module cmas_line_decoder (
  input  wire logic [5:0]                      field,
  input  wire logic                            enable,
  input  wire logic                            strobe,
  output cmas_pkg::cmas_line_sel_t             sel
);
  function automatic logic [cmas_pkg::LINES_W-1:0] one_of_eight(input logic [cmas_pkg::DIGIT_W-1:0] d, input logic en);
    logic [cmas_pkg::LINES_W-1:0] v;
    v = '0;
    if (en) begin
      v[d] = 1'b1;
    end
    return v;
  endfunction

  // The high octal digit picks the driver and the low one the switch.
  always_comb begin
    sel.driver     = one_of_eight(field[2*cmas_pkg::DIGIT_W-1:cmas_pkg::DIGIT_W], enable & strobe);
    sel.switch_sel = one_of_eight(field[cmas_pkg::DIGIT_W-1:0], enable & strobe);
  end
endmodule

// *** hw/cmas_addr_select.sv ***
module cmas_addr_select (
  input  wire logic                              clk,
  input  wire logic                              rstn,
  input  wire logic                              last_timing_slot,
  input  wire logic                              first_timing_slot,
  input  wire logic                              read_current_strobe,
  input  wire logic                              sense_gate_strobe,
  input  wire logic                              write_cycle,
  input  wire cmas_pkg::cmas_phase_t             phase,
  input  wire logic                              final_phase,
  input  wire logic                              skip,
  input  wire logic                              jump,
  input  wire logic                              page_current,
  input  wire logic [cmas_pkg::ADDR_W-1:0]       pc,
  input  wire logic [cmas_pkg::WORD_W-1:0]       sense_lower,
  input  wire logic [cmas_pkg::WORD_W-1:0]       sense_upper,
  input  wire logic [cmas_pkg::WORD_W-1:0]       sense_lower_stack2,
  input  wire logic [cmas_pkg::WORD_W-1:0]       sense_upper_stack2,
  output logic [cmas_pkg::ADDR_W-1:0]            addr_reg,
  output logic [cmas_pkg::WORD_W-1:0]            xfer_reg,
  output cmas_pkg::cmas_enables_t                enables_reg,
  output cmas_pkg::cmas_line_sel_t               y_sel_first,
  output cmas_pkg::cmas_line_sel_t               y_sel_second,
  output cmas_pkg::cmas_line_sel_t               x_sel_first,
  output cmas_pkg::cmas_line_sel_t               x_sel_second,
  output cmas_pkg::cmas_dir_t                    dir
);
  logic [cmas_pkg::ADDR_W-1:0] addr_next;
  cmas_pkg::cmas_enables_t     enables_next;
  logic [cmas_pkg::WORD_W-1:0] xfer_next;
  logic [cmas_pkg::WORD_W-1:0] sense_sel;
  logic                        x_first_en;
  logic                        x_second_en;
  logic                        upper_sel;

  function automatic cmas_pkg::cmas_enables_t decode_enables(input logic [cmas_pkg::ADDR_W-1:0] a);
    cmas_pkg::cmas_enables_t e;
    logic [1:0] stk;
    logic       up;
    e   = '0;
    stk = a[cmas_pkg::STK_HI:cmas_pkg::STK_LO];
    up  = a[cmas_pkg::MOD_BIT];
    if (stk == cmas_pkg::STACK_FIRST) begin
      e.y_stack_first_enable  = 1'b1;
      e.x_lower_module_enable = ~up;
      e.x_upper_module_enable = up;
    end else if (stk == cmas_pkg::STACK_SECOND) begin
      e.y_stack_second_enable        = 1'b1;
      e.x_lower_module_enable_stack2 = ~up;
      e.x_upper_module_enable_stack2 = up;
    end
    return e;
  endfunction

  // Address source follows machine phase and instruction flow.
  always_comb begin
    addr_next = addr_reg;
    if (final_phase) begin
      if (jump) begin
        addr_next = xfer_reg[cmas_pkg::ADDR_W-1:0];
      end else if (skip) begin
        addr_next = pc + cmas_pkg::PC_SKIP;
      end else begin
        addr_next = pc + cmas_pkg::PC_INC;
      end
    end else if (phase == cmas_pkg::CMAS_FETCH) begin
      // Page-relative operand or address-word address; page zero clears the high bits.
      addr_next = '0;
      addr_next[cmas_pkg::PAGE_HI:cmas_pkg::PAGE_LO] = xfer_reg[cmas_pkg::PAGE_HI:cmas_pkg::PAGE_LO];
      if (page_current) begin
        addr_next[cmas_pkg::ADDR_W-1:cmas_pkg::PAGE_HI+1] = addr_reg[cmas_pkg::ADDR_W-1:cmas_pkg::PAGE_HI+1];
      end
    end else if (phase == cmas_pkg::CMAS_INDIRECT) begin
      addr_next = xfer_reg[cmas_pkg::ADDR_W-1:0];
    end
  end

  always_comb begin
    enables_next = decode_enables(addr_next);
  end

  // Address and enables update together at the end of the last slot.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_reg <= cmas_pkg::ADDR_RST;
    end else if (last_timing_slot) begin
      addr_reg <= addr_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enables_reg <= '0;
    end else if (last_timing_slot) begin
      enables_reg <= enables_next;
    end
  end

  assign x_first_en  = enables_reg.x_lower_module_enable | enables_reg.x_upper_module_enable;
  assign x_second_en = enables_reg.x_lower_module_enable_stack2 | enables_reg.x_upper_module_enable_stack2;
  assign upper_sel   = enables_reg.x_upper_module_enable | enables_reg.x_upper_module_enable_stack2;

  // Reads run switch to driver; upper module flips the X direction.
  always_comb begin
    dir.y_sw_to_drv = ~write_cycle;
    dir.x_sw_to_drv = ~write_cycle ^ upper_sel;
  end

  // Y gates qualified per stack, X gates by module enables, all strobed by read.
  cmas_line_decoder u_y_first (
    .field  (addr_reg[cmas_pkg::Y_HI:cmas_pkg::Y_LO]),
    .enable (enables_reg.y_stack_first_enable),
    .strobe (read_current_strobe),
    .sel    (y_sel_first)
  );
  cmas_line_decoder u_y_second (
    .field  (addr_reg[cmas_pkg::Y_HI:cmas_pkg::Y_LO]),
    .enable (enables_reg.y_stack_second_enable),
    .strobe (read_current_strobe),
    .sel    (y_sel_second)
  );
  cmas_line_decoder u_x_first (
    .field  (addr_reg[cmas_pkg::X_HI:cmas_pkg::X_LO]),
    .enable (x_first_en),
    .strobe (read_current_strobe),
    .sel    (x_sel_first)
  );
  cmas_line_decoder u_x_second (
    .field  (addr_reg[cmas_pkg::X_HI:cmas_pkg::X_LO]),
    .enable (x_second_en),
    .strobe (read_current_strobe),
    .sel    (x_sel_second)
  );

  // Only the module named by the X enables passes its sense bits.
  always_comb begin
    sense_sel = ({cmas_pkg::WORD_W{enables_reg.x_lower_module_enable}} & sense_lower)
              | ({cmas_pkg::WORD_W{enables_reg.x_upper_module_enable}} & sense_upper)
              | ({cmas_pkg::WORD_W{enables_reg.x_lower_module_enable_stack2}} & sense_lower_stack2)
              | ({cmas_pkg::WORD_W{enables_reg.x_upper_module_enable_stack2}} & sense_upper_stack2);
  end

  // The transfer register clears at the first slot of a read and collects ones at the sense strobe.
  always_comb begin
    xfer_next = xfer_reg;
    if (first_timing_slot && !write_cycle) begin
      xfer_next = cmas_pkg::WORD_RST;
    end else if (sense_gate_strobe && !write_cycle) begin
      xfer_next = xfer_reg | sense_sel;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xfer_reg <= cmas_pkg::WORD_RST;
    end else begin
      xfer_reg <= xfer_next;
    end
  end

  chk_enable_onehot: assert property (@(posedge clk) disable iff (!rstn)
    $past(last_timing_slot) |-> $onehot0({enables_reg.x_lower_module_enable, enables_reg.x_upper_module_enable,
      enables_reg.x_lower_module_enable_stack2, enables_reg.x_upper_module_enable_stack2}))
    else $error("More than one module X enable is active.");
  chk_module_bit: assert property (@(posedge clk) disable iff (!rstn)
    ($past(last_timing_slot) && addr_reg[cmas_pkg::STK_HI:cmas_pkg::STK_LO] == cmas_pkg::STACK_FIRST) |->
      (enables_reg.x_upper_module_enable == addr_reg[cmas_pkg::MOD_BIT]))
    else $error("Module enable does not follow the module address bit.");
  chk_strobe_one: assert property (@(posedge clk) disable iff (!rstn)
    (read_current_strobe && enables_reg.y_stack_first_enable) |->
      ($onehot(y_sel_first.driver) && $onehot(y_sel_first.switch_sel)))
    else $error("Y selection is not exactly one driver and one switch.");
  chk_no_strobe: assert property (@(posedge clk) disable iff (!rstn)
    !read_current_strobe |-> ({y_sel_first, y_sel_second, x_sel_first, x_sel_second} == '0))
    else $error("Lines selected without the read strobe.");
  chk_x_digit: assert property (@(posedge clk) disable iff (!rstn)
    (read_current_strobe && x_first_en) |->
      x_sel_first.driver[addr_reg[cmas_pkg::X_HI:cmas_pkg::X_HI-cmas_pkg::DIGIT_W+1]])
    else $error("X driver does not match the high octal digit.");
  chk_y_digit: assert property (@(posedge clk) disable iff (!rstn)
    (read_current_strobe && enables_reg.y_stack_first_enable) |->
      y_sel_first.switch_sel[addr_reg[cmas_pkg::Y_LO+cmas_pkg::DIGIT_W-1:cmas_pkg::Y_LO]])
    else $error("Y switch does not match the low octal digit.");
  chk_skip_load: assert property (@(posedge clk) disable iff (!rstn)
    (last_timing_slot && final_phase && !jump && skip) |=> addr_reg == $past(pc) + cmas_pkg::PC_SKIP)
    else $error("Skip did not load program counter plus two.");
  chk_inc_load: assert property (@(posedge clk) disable iff (!rstn)
    (last_timing_slot && final_phase && !jump && !skip) |=> addr_reg == $past(pc) + cmas_pkg::PC_INC)
    else $error("Final phase did not load program counter plus one.");
  chk_jump_load: assert property (@(posedge clk) disable iff (!rstn)
    (last_timing_slot && final_phase && jump) |=> addr_reg == $past(xfer_reg[cmas_pkg::ADDR_W-1:0]))
    else $error("Jump did not load the transfer register.");
  chk_fetch_page: assert property (@(posedge clk) disable iff (!rstn)
    (last_timing_slot && !final_phase && phase == cmas_pkg::CMAS_FETCH && !page_current) |=>
      (addr_reg[cmas_pkg::ADDR_W-1:cmas_pkg::PAGE_HI+1] == '0 &&
       addr_reg[cmas_pkg::PAGE_HI:cmas_pkg::PAGE_LO] == $past(xfer_reg[cmas_pkg::PAGE_HI:cmas_pkg::PAGE_LO])))
    else $error("Page zero fetch did not load the page offset alone.");
  chk_indirect_load: assert property (@(posedge clk) disable iff (!rstn)
    (last_timing_slot && !final_phase && phase == cmas_pkg::CMAS_INDIRECT) |=>
      addr_reg == $past(xfer_reg[cmas_pkg::ADDR_W-1:0]))
    else $error("Indirect phase did not load the address word.");
  chk_xfer_clear: assert property (@(posedge clk) disable iff (!rstn)
    (first_timing_slot && !write_cycle) |=> xfer_reg == cmas_pkg::WORD_RST)
    else $error("Transfer register not cleared at the first slot.");
  chk_lower_gate: assert property (@(posedge clk) disable iff (!rstn)
    (sense_gate_strobe && !first_timing_slot && !write_cycle && enables_reg.x_lower_module_enable) |=>
      xfer_reg == ($past(xfer_reg) | $past(sense_lower)))
    else $error("Lower module read gated sense bits of another module.");
  chk_write_hold: assert property (@(posedge clk) disable iff (!rstn)
    write_cycle |=> $stable(xfer_reg))
    else $error("Transfer register changed during a write cycle.");
  chk_upper_dir: assert property (@(posedge clk) disable iff (!rstn)
    upper_sel |-> (dir.x_sw_to_drv != dir.y_sw_to_drv))
    else $error("Upper module X direction not reversed.");
endmodule

// *** bench/cmas_core_stack.sv ***
module cmas_core_stack (
  input  wire cmas_pkg::cmas_line_sel_t y_sel_first,
  input  wire cmas_pkg::cmas_line_sel_t y_sel_second,
  input  wire cmas_pkg::cmas_line_sel_t x_sel_first,
  input  wire cmas_pkg::cmas_line_sel_t x_sel_second,
  input  wire cmas_pkg::cmas_dir_t      dir,
  output logic [15:0]                   sense_lower,
  output logic [15:0]                   sense_upper,
  output logic [15:0]                   sense_lower_stack2,
  output logic [15:0]                   sense_upper_stack2
);
  timeunit 1ns;
  timeprecision 1ps;
  logic upper;
  function automatic logic [2:0] idx(input logic [7:0] v);
    idx = 3'h0;
    for (int i = 0; i < 8; i++)
      if (v[i]) idx = i[2:0];
  endfunction
  function automatic logic [15:0] word(input logic [14:0] a);
    word = {a[3:0], a[14:3]} ^ 16'h5a3c;
  endfunction
  // A word is read only with exactly one driver and one switch on each axis.
  function automatic logic hit(input cmas_pkg::cmas_line_sel_t y, x);
    hit = $onehot(y.driver) && $onehot(y.switch_sel) && $onehot(x.driver) && $onehot(x.switch_sel);
  endfunction
  function automatic logic [11:0] line(input cmas_pkg::cmas_line_sel_t y, x);
    line = {idx(y.driver), idx(y.switch_sel), idx(x.driver), idx(x.switch_sel)};
  endfunction
  // Unread amplifiers stay cut off and show logic 0.
  always_comb begin
    upper = dir.x_sw_to_drv != dir.y_sw_to_drv;
    sense_lower = 16'h0000;
    sense_upper = 16'h0000;
    sense_lower_stack2 = 16'h0000;
    sense_upper_stack2 = 16'h0000;
    if (hit(y_sel_first, x_sel_first)) begin
      if (upper) sense_upper = word({2'h0, 1'b1, line(y_sel_first, x_sel_first)});
      else sense_lower = word({2'h0, 1'b0, line(y_sel_first, x_sel_first)});
    end
    if (hit(y_sel_second, x_sel_second)) begin
      if (upper) sense_upper_stack2 = word({2'h1, 1'b1, line(y_sel_second, x_sel_second)});
      else sense_lower_stack2 = word({2'h1, 1'b0, line(y_sel_second, x_sel_second)});
    end
  end
endmodule

// *** bench/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, last_timing_slot = 1'b0, first_timing_slot = 1'b0;
  logic read_current_strobe = 1'b0, sense_gate_strobe = 1'b0, write_cycle = 1'b0;
  logic final_phase = 1'b0, skip = 1'b0, jump = 1'b0, page_current = 1'b0;
  cmas_pkg::cmas_phase_t phase = cmas_pkg::CMAS_FETCH;
  logic [14:0] pc = 15'h0000, addr_reg;
  logic [15:0] xfer_reg, sense_lower, sense_upper, sense_lower_stack2, sense_upper_stack2;
  cmas_pkg::cmas_enables_t enables_reg;
  cmas_pkg::cmas_line_sel_t y_sel_first, y_sel_second, x_sel_first, x_sel_second;
  cmas_pkg::cmas_dir_t dir;
  int num_errors = 0, samples_checked = 0;
  always #5 clk = ~clk;
  cmas_addr_select dut (.clk, .rstn, .last_timing_slot, .first_timing_slot, .read_current_strobe,
    .sense_gate_strobe, .write_cycle, .phase, .final_phase, .skip, .jump, .page_current, .pc, .sense_lower,
    .sense_upper, .sense_lower_stack2, .sense_upper_stack2, .addr_reg, .xfer_reg, .enables_reg,
    .y_sel_first, .y_sel_second, .x_sel_first, .x_sel_second, .dir);
  cmas_core_stack mem (.y_sel_first, .y_sel_second, .x_sel_first, .x_sel_second, .dir, .sense_lower,
    .sense_upper, .sense_lower_stack2, .sense_upper_stack2);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic load(input cmas_pkg::cmas_phase_t ph, input logic f, s, j, p, input logic [14:0] pv);
    @(posedge clk);
    phase <= ph;
    final_phase <= f;
    skip <= s;
    jump <= j;
    page_current <= p;
    pc <= pv;
    last_timing_slot <= 1'b1;
    @(posedge clk);
    last_timing_slot <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic w);
    logic [14:0] a;
    logic [15:0] yl, xl, old;
    logic        s0, s1;
    a = addr_reg;
    old = xfer_reg;
    s0 = a[14:13] == 2'h0;
    s1 = a[14:13] == 2'h1;
    yl = {8'h01 << a[11:9], 8'h01 << a[8:6]};
    xl = {8'h01 << a[5:3], 8'h01 << a[2:0]};
    chk("enables", {s0 && !a[12], s0 && a[12], s1 && !a[12], s1 && a[12], s0, s1}, enables_reg);
    @(posedge clk);
    write_cycle <= w;
    first_timing_slot <= 1'b1;
    read_current_strobe <= 1'b1;
    @(posedge clk);
    first_timing_slot <= 1'b0;
    sense_gate_strobe <= 1'b1;
    #1;
    chk("y_sel", s1 ? {yl, 16'h0000} : s0 ? {16'h0000, yl} : 32'h0, {y_sel_second, y_sel_first});
    chk("x_sel", s1 ? {xl, 16'h0000} : s0 ? {16'h0000, xl} : 32'h0, {x_sel_second, x_sel_first});
    chk("dir", {!w, ((s0 || s1) && a[12]) ^ !w}, dir);
    if (!w) chk("xfer_clear", 16'h0000, xfer_reg);
    @(posedge clk);
    sense_gate_strobe <= 1'b0;
    read_current_strobe <= 1'b0;
    write_cycle <= 1'b0;
    #1;
    chk("xfer", w ? old : ((s0 || s1) ? mem.word(a) : 16'h0000), xfer_reg);
    chk("sel_idle_first", 32'h0, {x_sel_first, y_sel_first});
    chk("sel_idle_second", 32'h0, {x_sel_second, y_sel_second});
  endtask
  task automatic t_read(input logic [14:0] a);
    load(cmas_pkg::CMAS_EXECUTE, 1'b1, 1'b0, 1'b0, 1'b0, a - 15'h0001);
    chk("addr_inc", a, addr_reg);
    rd(1'b0);
    rd(1'b1);
    $display("test read %h done", a);
  endtask
  task automatic t_flow;
    logic [15:0] w;
    load(cmas_pkg::CMAS_EXECUTE, 1'b1, 1'b1, 1'b0, 1'b0, 15'h1233);
    chk("addr_skip", 15'h1235, addr_reg);
    rd(1'b0);
    w = xfer_reg;
    load(cmas_pkg::CMAS_FETCH, 1'b0, 1'b0, 1'b0, 1'b1, 15'h0000);
    chk("addr_page", {5'h04, w[9:0]}, addr_reg);
    rd(1'b0);
    w = xfer_reg;
    load(cmas_pkg::CMAS_INDIRECT, 1'b0, 1'b0, 1'b0, 1'b0, 15'h0000);
    chk("addr_ind", w[14:0], addr_reg);
    rd(1'b0);
    w = xfer_reg;
    load(cmas_pkg::CMAS_FETCH, 1'b0, 1'b0, 1'b0, 1'b0, 15'h0000);
    chk("addr_zero_page", {5'h00, w[9:0]}, addr_reg);
    load(cmas_pkg::CMAS_EXECUTE, 1'b0, 1'b0, 1'b0, 1'b0, 15'h0000);
    chk("addr_hold", {5'h00, w[9:0]}, addr_reg);
    rd(1'b0);
    w = xfer_reg;
    load(cmas_pkg::CMAS_EXECUTE, 1'b1, 1'b1, 1'b1, 1'b0, 15'h0000);
    chk("addr_jump", w[14:0], addr_reg);
    $display("test flow done");
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("reset", 31'h0, {addr_reg, xfer_reg});
    chk("reset_enables", 32'h0, enables_reg);
    t_read(15'h0ab8);
    t_read(15'h1ab8);
    t_read(15'h2345);
    t_read(15'h3fff);
    t_read(15'h1000);
    t_flow;
    close_out;
  end
endmodule
